// ==== src/rph_core.sv ====
// Purpose: packet handler: sync search, length, address filter,
//          de-whitening, crc check, status append, tx whitening
// Assumes: rx bit and strobe come from another domain
// Notes:   registers on a plain strobe port, read data one cycle later
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module rph_core (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic [15:0]       reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic [7:0]             reg_rdata_o,
    input  wire logic              rx_bit_i,
    input  wire logic              rx_strobe_i,
    input  wire logic [7:0]        rssi_i,
    input  wire logic [6:0]        lqi_i,
    input  wire logic              tx_start_i,
    input  wire logic              tx_req_i,
    input  wire logic              tx_bit_i,
    output logic                   tx_bit_o,
    output logic [15:0]            tx_crc_o,
    output rph_pkg::rph_byte_s     rx_byte_o,
    output logic                   crc_ok_o,
    output logic                   pkt_done_o,
    output logic                   pkt_abort_o,
    output logic                   debug_port_pin_o
);
    logic [7:0]  sync_hi_q, sync_lo_q, len_lim_q, ctrl_up_q, ctrl_lo_q;
    logic [7:0]  dev_adr_q, dbg_cfg_q;
    logic        rx_bit_m_q, rx_bit_s_q, rx_stb_m_q, rx_stb_s_q, rx_stb_d_q;
    logic        prev_q;
    logic [7:0]  pq_q;
    logic [15:0] sync_sh_q;
    logic [8:0]  pn_q, tx_pn_q;
    logic [15:0] crc_q;
    logic [2:0]  bit_cnt_q;
    logic [6:0]  byte_sh_q;
    logic [7:0]  rem_q;
    logic        crc_cnt_q, st_cnt_q;
    rph_pkg::rph_state_e state_q;

    logic        bit_ev, hunting, pq_ok, sync_hit, db, byte_done, crc_en, apnd;
    logic        fixed_len, white;
    logic [7:0]  byte_val;
    logic [15:0] crc_nx, poly;
    logic [2:0]  preamble_quality_threshold;
    logic [1:0]  af;

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b,
                                             input logic [15:0] p);
        return {c[14:0], 1'b0} ^ ((c[15] ^ b) ? p : 16'h0000);
    endfunction : crc_step

    function automatic logic [8:0] pn9_step(input logic [8:0] p);
        return {p[0] ^ p[5], p[8:1]};
    endfunction : pn9_step

    function automatic logic addr_pass(input logic [7:0] b,
                                       input logic [7:0] a,
                                       input logic [1:0] m);
        logic ok;
        ok = (b == a);
        if (m == rph_pkg::AF_NONE) begin
            ok = 1'b1;
        end else if (m == rph_pkg::AF_BC00) begin
            ok = ok | (b == rph_pkg::BCAST_LO);
        end else if (m != rph_pkg::AF_ADDR) begin
            ok = ok | (b == rph_pkg::BCAST_LO) | (b == rph_pkg::BCAST_HI);
        end
        return ok;
    endfunction : addr_pass

    assign preamble_quality_threshold       = ctrl_up_q[rph_pkg::PQT_MSB:rph_pkg::PQT_LSB];
    assign apnd      = ctrl_up_q[rph_pkg::APPEND_B];
    assign af        = ctrl_up_q[rph_pkg::AF_MSB:rph_pkg::AF_LSB];
    assign white     = ctrl_lo_q[rph_pkg::WHITE_B];
    assign crc_en    = ctrl_lo_q[rph_pkg::CRCEN_B];
    assign fixed_len = ctrl_lo_q[rph_pkg::LEN_MSB:rph_pkg::LEN_LSB] == rph_pkg::LEN_FIXED;
    // legacy crc shares the seed, only the polynomial differs
    assign poly      = ctrl_lo_q[rph_pkg::LCRC_B] ? rph_pkg::LCRC_POLY : rph_pkg::CRC_POLY;

    // registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync_hi_q <= rph_pkg::RST_SYNC_HI;
            sync_lo_q <= rph_pkg::RST_SYNC_LO;
            len_lim_q <= rph_pkg::RST_PKT_LEN;
            ctrl_up_q <= rph_pkg::RST_CTRL_UP;
            ctrl_lo_q <= rph_pkg::RST_CTRL_LO;
            dev_adr_q <= rph_pkg::RST_DEV_ADR;
            dbg_cfg_q <= rph_pkg::RST_DBG_CFG;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                rph_pkg::ADR_SYNC_HI: sync_hi_q <= reg_wdata_i;
                rph_pkg::ADR_SYNC_LO: sync_lo_q <= reg_wdata_i;
                rph_pkg::ADR_PKT_LEN: len_lim_q <= reg_wdata_i;
                rph_pkg::ADR_CTRL_UP: ctrl_up_q <= reg_wdata_i & rph_pkg::MSK_CTRL_UP;
                rph_pkg::ADR_CTRL_LO: ctrl_lo_q <= reg_wdata_i & rph_pkg::MSK_CTRL_LO;
                rph_pkg::ADR_DEV_ADR: dev_adr_q <= reg_wdata_i;
                rph_pkg::ADR_DBG_CFG: dbg_cfg_q <= reg_wdata_i & rph_pkg::MSK_DBG_CFG;
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                rph_pkg::ADR_SYNC_HI: reg_rdata_o <= sync_hi_q;
                rph_pkg::ADR_SYNC_LO: reg_rdata_o <= sync_lo_q;
                rph_pkg::ADR_PKT_LEN: reg_rdata_o <= len_lim_q;
                rph_pkg::ADR_CTRL_UP: reg_rdata_o <= ctrl_up_q;
                rph_pkg::ADR_CTRL_LO: reg_rdata_o <= ctrl_lo_q;
                rph_pkg::ADR_DEV_ADR: reg_rdata_o <= dev_adr_q;
                rph_pkg::ADR_DBG_CFG: reg_rdata_o <= dbg_cfg_q;
                rph_pkg::ADR_PQ_CNT:  reg_rdata_o <= pq_q;
                rph_pkg::ADR_STATUS:  reg_rdata_o <= {6'h00, crc_ok_o, ~hunting};
                default:              reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // pin synchronisers; edge detect reads only the second stage onward
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_bit_m_q <= 1'b0;
            rx_bit_s_q <= 1'b0;
            rx_stb_m_q <= 1'b0;
            rx_stb_s_q <= 1'b0;
            rx_stb_d_q <= 1'b0;
        end else begin
            rx_bit_m_q <= rx_bit_i;
            rx_bit_s_q <= rx_bit_m_q;
            rx_stb_m_q <= rx_strobe_i;
            rx_stb_s_q <= rx_stb_m_q;
            rx_stb_d_q <= rx_stb_s_q;
        end
    end

    assign bit_ev    = rx_stb_s_q & ~rx_stb_d_q;
    assign hunting   = state_q == rph_pkg::RPH_HUNT;
    assign pq_ok     = (preamble_quality_threshold == 3'h0) || (pq_q >= {3'h0, preamble_quality_threshold, 2'h0});
    assign sync_hit  = bit_ev & hunting & pq_ok &
                       ({sync_sh_q[14:0], rx_bit_s_q} == {sync_hi_q, sync_lo_q});
    assign db        = rx_bit_s_q ^ (white & pn_q[0]);
    assign byte_done = bit_ev & ~hunting & (state_q != rph_pkg::RPH_STAT) &
                       (bit_cnt_q == 3'h7);
    assign byte_val  = {byte_sh_q, db};
    assign crc_nx    = crc_step(crc_q, db, poly);

    // preamble quality and sync shift register
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pq_q      <= 8'h00;
            prev_q    <= 1'b0;
            sync_sh_q <= 16'h0000;
        end else if (!hunting) begin
            pq_q      <= 8'h00;
        end else if (bit_ev) begin
            prev_q    <= rx_bit_s_q;
            sync_sh_q <= {sync_sh_q[14:0], rx_bit_s_q};
            if (rx_bit_s_q != prev_q) begin
                pq_q <= (pq_q == rph_pkg::PQ_MAX) ? pq_q : pq_q + 8'h01;
            end else begin
                // saturate instead of wrapping into a false high quality
                pq_q <= (pq_q < rph_pkg::PQ_DEC) ? 8'h00 : pq_q - rph_pkg::PQ_DEC;
            end
        end
    end

    // de-whitening, byte assembly and crc accumulation
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pn_q      <= rph_pkg::PN9_SEED;
            crc_q     <= rph_pkg::CRC_SEED;
            bit_cnt_q <= 3'h0;
            byte_sh_q <= 7'h00;
        end else if (sync_hit) begin
            pn_q      <= rph_pkg::PN9_SEED;
            crc_q     <= rph_pkg::CRC_SEED;
            bit_cnt_q <= 3'h0;
        end else if (bit_ev && !hunting && state_q != rph_pkg::RPH_STAT) begin
            pn_q      <= pn9_step(pn_q);
            crc_q     <= crc_nx;
            bit_cnt_q <= bit_cnt_q + 3'h1;
            byte_sh_q <= byte_val[6:0];
        end
    end

    // packet sequencer
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_q     <= rph_pkg::RPH_HUNT;
            rem_q       <= 8'h00;
            crc_cnt_q   <= 1'b0;
            st_cnt_q    <= 1'b0;
            crc_ok_o    <= 1'b0;
            pkt_done_o  <= 1'b0;
            pkt_abort_o <= 1'b0;
            rx_byte_o   <= '0;
        end else begin
            pkt_done_o      <= 1'b0;
            pkt_abort_o     <= 1'b0;
            rx_byte_o.valid <= 1'b0;
            unique case (state_q)
                rph_pkg::RPH_HUNT: begin
                    crc_cnt_q <= 1'b0;
                    st_cnt_q  <= 1'b0;
                    if (sync_hit && !fixed_len) begin
                        state_q <= rph_pkg::RPH_LEN;
                    end else if (sync_hit && len_lim_q != 8'h00) begin
                        rem_q   <= len_lim_q;
                        state_q <= (af != rph_pkg::AF_NONE) ? rph_pkg::RPH_ADR
                                                              : rph_pkg::RPH_PAY;
                    end
                end
                rph_pkg::RPH_LEN: begin
                    if (byte_done) begin
                        rx_byte_o <= '{data: byte_val, valid: 1'b1, status: 1'b0};
                        rem_q     <= byte_val;
                        if (byte_val == 8'h00 || byte_val > len_lim_q) begin
                            state_q     <= rph_pkg::RPH_HUNT;
                            pkt_abort_o <= 1'b1;
                        end else begin
                            state_q <= (af != rph_pkg::AF_NONE) ? rph_pkg::RPH_ADR
                                                                  : rph_pkg::RPH_PAY;
                        end
                    end
                end
                rph_pkg::RPH_ADR, rph_pkg::RPH_PAY: begin
                    if (byte_done) begin
                        rx_byte_o <= '{data: byte_val, valid: 1'b1, status: 1'b0};
                        rem_q     <= rem_q - 8'h01;
                        if (state_q == rph_pkg::RPH_ADR &&
                            !addr_pass(byte_val, dev_adr_q, af)) begin
                            state_q     <= rph_pkg::RPH_HUNT;
                            pkt_abort_o <= 1'b1;
                        end else if (rem_q != 8'h01) begin
                            state_q <= rph_pkg::RPH_PAY;
                        end else if (crc_en) begin
                            state_q <= rph_pkg::RPH_CRC;
                        end else begin
                            crc_ok_o <= 1'b0;
                            state_q  <= apnd ? rph_pkg::RPH_STAT : rph_pkg::RPH_HUNT;
                            pkt_done_o <= ~apnd;
                        end
                    end
                end
                rph_pkg::RPH_CRC: begin
                    if (byte_done) begin
                        crc_cnt_q <= 1'b1;
                        if (crc_cnt_q) begin
                            crc_ok_o   <= crc_nx == 16'h0000;
                            state_q    <= apnd ? rph_pkg::RPH_STAT : rph_pkg::RPH_HUNT;
                            pkt_done_o <= ~apnd;
                        end
                    end
                end
                rph_pkg::RPH_STAT: begin
                    // two status bytes in consecutive cycles, no bit timing
                    st_cnt_q <= 1'b1;
                    if (!st_cnt_q) begin
                        rx_byte_o <= '{data: rssi_i, valid: 1'b1, status: 1'b1};
                    end else begin
                        rx_byte_o  <= '{data: {crc_ok_o, lqi_i}, valid: 1'b1,
                                        status: 1'b1};
                        state_q    <= rph_pkg::RPH_HUNT;
                        pkt_done_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    // transmit: whitening, test pattern, crc over raw data
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_pn_q  <= rph_pkg::PN9_SEED;
            tx_crc_o <= rph_pkg::CRC_SEED;
            tx_bit_o <= 1'b0;
        end else if (tx_start_i) begin
            tx_pn_q  <= rph_pkg::PN9_SEED;
            tx_crc_o <= rph_pkg::CRC_SEED;
        end else if (tx_req_i) begin
            tx_pn_q <= pn9_step(tx_pn_q);
            if (ctrl_lo_q[rph_pkg::FMT_MSB:rph_pkg::FMT_LSB] == rph_pkg::FMT_RANDOM) begin
                tx_bit_o <= tx_pn_q[0];
            end else begin
                // reserved formats behave as normal
                tx_bit_o <= tx_bit_i ^ (white & tx_pn_q[0]);
            end
            if (crc_en) begin
                tx_crc_o <= crc_step(tx_crc_o, tx_bit_i, poly);
            end
        end
    end

    // debug pin
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            debug_port_pin_o <= 1'b0;
        end else begin
            unique case (dbg_cfg_q[rph_pkg::DBG_MSB:0])
                rph_pkg::DBG_PQ_OK:  debug_port_pin_o <= pq_ok ^ dbg_cfg_q[rph_pkg::DBG_INV_B];
                rph_pkg::DBG_IN_PKT: debug_port_pin_o <= ~hunting ^ dbg_cfg_q[rph_pkg::DBG_INV_B];
                rph_pkg::DBG_CRC_OK: debug_port_pin_o <= crc_ok_o ^ dbg_cfg_q[rph_pkg::DBG_INV_B];
                rph_pkg::DBG_RX_BIT: debug_port_pin_o <= rx_bit_s_q ^
                                                         dbg_cfg_q[rph_pkg::DBG_INV_B];
                default:             debug_port_pin_o <= dbg_cfg_q[rph_pkg::DBG_INV_B];
            endcase
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    a_pq_restart: assert property (!hunting |=> pq_q == 8'h00)
        else $error("quality counter not cleared outside search");
    a_pq_down: assert property (bit_ev && hunting && rx_bit_s_q == prev_q
        && pq_q >= 8'h08 |=> pq_q == $past(pq_q) - 8'h08)
        else $error("quality counter did not drop by 8");
    a_pq_up: assert property (bit_ev && hunting && rx_bit_s_q != prev_q
        && pq_q != 8'hFF |=> pq_q == $past(pq_q) + 8'h01)
        else $error("quality counter did not rise by 1");
    a_sync_gate: assert property (hunting && !pq_ok |=> hunting)
        else $error("sync accepted below quality threshold");
    a_len_limit: assert property (state_q == rph_pkg::RPH_LEN && byte_done
        && byte_val > len_lim_q |=> hunting && pkt_abort_o)
        else $error("over-long packet not dropped");
    a_addr_drop: assert property (state_q == rph_pkg::RPH_ADR && byte_done
        && af == rph_pkg::AF_ADDR && byte_val != dev_adr_q |=> hunting)
        else $error("foreign address not dropped");
    a_fixed_len: assert property (sync_hit && fixed_len && len_lim_q != 8'h00
        |=> rem_q == $past(len_lim_q) && !hunting)
        else $error("fixed length not loaded");
    a_stat_pair: assert property (state_q == rph_pkg::RPH_CRC && byte_done && crc_cnt_q
        && apnd |=> state_q == rph_pkg::RPH_STAT ##1 rx_byte_o.status ##1
        rx_byte_o.status && hunting)
        else $error("status bytes not appended");
    a_tx_random: assert property (tx_req_i && !tx_start_i && ctrl_lo_q[5:4] == 2'h2
        |=> tx_bit_o == $past(tx_pn_q[0]))
        else $error("test pattern not sent");
endmodule : rph_core

// ==== src/rph_pkg.sv ====
// Purpose: shared constants and types of the radio packet handler
// Assumes: 8-bit registers at 16-bit byte addresses
// Notes:   one value per name; the module uses them by full path
package rph_pkg;
    // register addresses
    localparam logic [15:0] ADR_SYNC_HI  = 16'hDF00;
    localparam logic [15:0] ADR_SYNC_LO  = 16'hDF01;
    localparam logic [15:0] ADR_PKT_LEN  = 16'hDF02;
    localparam logic [15:0] ADR_CTRL_UP  = 16'hDF03;
    localparam logic [15:0] ADR_CTRL_LO  = 16'hDF04;
    localparam logic [15:0] ADR_DEV_ADR  = 16'hDF05;
    localparam logic [15:0] ADR_DBG_CFG  = 16'hDF31;
    localparam logic [15:0] ADR_PQ_CNT   = 16'hDF3A;
    localparam logic [15:0] ADR_STATUS   = 16'hDF3B;
    // reset values
    localparam logic [7:0]  RST_SYNC_HI  = 8'hD3;
    localparam logic [7:0]  RST_SYNC_LO  = 8'h91;
    localparam logic [7:0]  RST_PKT_LEN  = 8'hFF;
    localparam logic [7:0]  RST_CTRL_UP  = 8'h04;
    localparam logic [7:0]  RST_CTRL_LO  = 8'h45;
    localparam logic [7:0]  RST_DEV_ADR  = 8'h00;
    localparam logic [7:0]  RST_DBG_CFG  = 8'h00;
    // writable bits; the rest read as zero
    localparam logic [7:0]  MSK_CTRL_UP  = 8'hE7;
    localparam logic [7:0]  MSK_CTRL_LO  = 8'h7F;
    localparam logic [7:0]  MSK_DBG_CFG  = 8'h7F;
    // field positions
    localparam int PQT_MSB   = 7;
    localparam int PQT_LSB   = 5;
    localparam int APPEND_B  = 2;
    localparam int AF_MSB    = 1;
    localparam int AF_LSB    = 0;
    localparam int WHITE_B   = 6;
    localparam int FMT_MSB   = 5;
    localparam int FMT_LSB   = 4;
    localparam int LCRC_B    = 3;
    localparam int CRCEN_B   = 2;
    localparam int LEN_MSB   = 1;
    localparam int LEN_LSB   = 0;
    localparam int DBG_INV_B = 6;
    localparam int DBG_MSB   = 5;
    // field codes
    localparam logic [1:0]  LEN_FIXED    = 2'h0;
    localparam logic [1:0]  LEN_VAR      = 2'h1;
    localparam logic [1:0]  AF_NONE      = 2'h0;
    localparam logic [1:0]  AF_ADDR      = 2'h1;
    localparam logic [1:0]  AF_BC00      = 2'h2;
    localparam logic [1:0]  FMT_RANDOM   = 2'h2;
    localparam logic [7:0]  BCAST_LO     = 8'h00;
    localparam logic [7:0]  BCAST_HI     = 8'hFF;
    // preamble quality arithmetic
    localparam logic [7:0]  PQ_DEC       = 8'h08;
    localparam logic [7:0]  PQ_MAX       = 8'hFF;
    // generators
    localparam logic [8:0]  PN9_SEED     = 9'h1FF;
    localparam logic [15:0] CRC_SEED     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'h8005;
    localparam logic [15:0] LCRC_POLY    = 16'h1021;
    // debug signal codes
    localparam logic [5:0]  DBG_PQ_OK    = 6'h00;
    localparam logic [5:0]  DBG_IN_PKT   = 6'h01;
    localparam logic [5:0]  DBG_CRC_OK   = 6'h02;
    localparam logic [5:0]  DBG_RX_BIT   = 6'h03;

    typedef enum logic [5:0] {
        RPH_HUNT = 6'h01,
        RPH_LEN  = 6'h02,
        RPH_ADR  = 6'h04,
        RPH_PAY  = 6'h08,
        RPH_CRC  = 6'h10,
        RPH_STAT = 6'h20
    } rph_state_e;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
        logic       status;
    } rph_byte_s;
endpackage : rph_pkg

// ==== tb/rph_radio.sv ====
// Purpose: remote radio that sends bits to the packet handler over the air link
// Assumes: bit settles 3 cycles before the strobe rises and is held past its fall
// Notes:   the strobe stands low between bits and frames
`timescale 1ns/10ps
module rph_radio (
    input  wire logic mclk_i,
    output logic      bit_o,
    output logic      strobe_o
);
    initial begin
        bit_o    = 1'b0;
        strobe_o = 1'b0;
    end
    // msb first, each level held at least 3 cycles so the 2-flop synchroniser sees it
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk_i) bit_o <= b[i];
            repeat (3) @(posedge mclk_i);
            strobe_o <= 1'b1;
            repeat (3) @(posedge mclk_i);
            strobe_o <= 1'b0;
            repeat (2) @(posedge mclk_i);
        end
    endtask : send_byte
    // a released line must not look like the last bit held
    task automatic release_line();
        @(posedge mclk_i) bit_o <= ~bit_o;
    endtask : release_line
endmodule : rph_radio

// ==== tb/rph_core_tb.sv ====
// Purpose: self-checking bench of the packet handler
// Assumes: crc off in the address and length tests so frames stay short
// Notes:   received bytes are gathered in a queue and judged after each frame
`timescale 1ns/10ps
module rph_core_tb;
    logic               mclk_i, rst_n_i, reg_wr_i, reg_rd_i;
    logic               tx_start_i, tx_req_i, tx_bit_i, tx_bit, pin, done, abort;
    logic               rx_bit, rx_strobe, crc_ok;
    logic [6:0]         lqi;
    logic [15:0]        reg_addr_i, tx_crc;
    logic [7:0]         reg_wdata_i, rdata, rssi;
    rph_pkg::rph_byte_s rx_byte;
    logic [8:0]         rxq[$];
    int                 n_done = 0, n_abort = 0, n_mismatch = 0, check_count = 0;

    rph_core dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(rdata), .rx_bit_i(rx_bit), .rx_strobe_i(rx_strobe),
        .rssi_i(rssi), .lqi_i(lqi), .tx_start_i(tx_start_i), .tx_req_i(tx_req_i),
        .tx_bit_i(tx_bit_i), .tx_bit_o(tx_bit), .tx_crc_o(tx_crc), .rx_byte_o(rx_byte),
        .crc_ok_o(crc_ok), .pkt_done_o(done), .pkt_abort_o(abort), .debug_port_pin_o(pin));
    rph_radio radio (.mclk_i(mclk_i), .bit_o(rx_bit), .strobe_o(rx_strobe));

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        if (rx_byte.valid === 1'b1) rxq.push_back({rx_byte.status, rx_byte.data});
        if (done === 1'b1) n_done++;
        if (abort === 1'b1) n_abort++;
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge mclk_i) reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge mclk_i) reg_rd_i <= 1'b0;
        @(negedge mclk_i) chk("rdata", exp, rdata);
    endtask : rd
    // frame: sync, two bytes; pay data bytes expected, then status when accepted
    task automatic pkt(input logic [7:0] b0, b1, input int pay, input logic ok);
        int         d0, a0;
        logic [8:0] e[$];
        d0 = n_done;
        a0 = n_abort;
        rxq.delete();
        radio.send_byte(8'hD3);
        radio.send_byte(8'h91);
        radio.send_byte(b0);
        radio.send_byte(b1);
        radio.release_line();
        repeat (20) @(posedge mclk_i);
        if (pay > 0) e.push_back({1'b0, b0});
        if (pay > 1) e.push_back({1'b0, b1});
        if (ok) e.push_back(9'h15A);
        if (ok) e.push_back(9'h133);
        chk("byte count", 16'(e.size()), 16'(rxq.size()));
        for (int i = 0; i < e.size() && i < rxq.size(); i++) begin
            chk("rx byte", 16'(e[i]), 16'(rxq[i]));
        end
        chk("done", 16'(ok), 16'(n_done - d0));
        chk("abort", 16'(pay > 0 && !ok), 16'(n_abort - a0));
    endtask : pkt

    task automatic t_regs();
        rd(rph_pkg::ADR_SYNC_HI, 8'hD3);
        rd(rph_pkg::ADR_SYNC_LO, 8'h91);
        rd(rph_pkg::ADR_PKT_LEN, 8'hFF);
        rd(rph_pkg::ADR_CTRL_UP, 8'h04);
        rd(rph_pkg::ADR_CTRL_LO, 8'h45);
        rd(rph_pkg::ADR_DEV_ADR, 8'h00);
        rd(rph_pkg::ADR_DBG_CFG, 8'h00);
        rd(16'hDF10, 8'h00);
        wr(rph_pkg::ADR_SYNC_LO, 8'h5C);
        rd(rph_pkg::ADR_SYNC_LO, 8'h5C);
        wr(rph_pkg::ADR_SYNC_LO, 8'h91);
        wr(rph_pkg::ADR_DBG_CFG, 8'hFF);
        rd(rph_pkg::ADR_DBG_CFG, 8'h7F);
    endtask : t_regs
    task automatic t_debug();
        // select code 05 drives a constant low, so only the invert bit shows
        wr(rph_pkg::ADR_DBG_CFG, 8'h45);
        repeat (3) @(posedge mclk_i);
        chk("debug pin", 16'h1, 16'(pin));
        wr(rph_pkg::ADR_DBG_CFG, 8'h05);
        repeat (3) @(posedge mclk_i);
        chk("debug pin", 16'h0, 16'(pin));
        // code 00 shows the quality gate, always open with a zero threshold
        wr(rph_pkg::ADR_DBG_CFG, 8'h00);
        repeat (3) @(posedge mclk_i);
        chk("debug pin", 16'h1, 16'(pin));
    endtask : t_debug
    task automatic t_tx();
        @(posedge mclk_i) tx_start_i <= 1'b1;
        @(posedge mclk_i) {tx_start_i, tx_req_i, tx_bit_i} <= 3'b011;
        @(posedge mclk_i) tx_req_i <= 1'b0;
        @(negedge mclk_i) chk("tx bit", 16'h0, 16'(tx_bit));
        chk("tx crc", 16'hFFFE, tx_crc);
        // test pattern: a raw 1 would whiten to 0, the generator gives 1
        wr(rph_pkg::ADR_CTRL_LO, 8'h65);
        @(posedge mclk_i) tx_start_i <= 1'b1;
        @(posedge mclk_i) {tx_start_i, tx_req_i, tx_bit_i} <= 3'b011;
        @(posedge mclk_i) tx_req_i <= 1'b0;
        @(negedge mclk_i) chk("tx bit", 16'h1, 16'(tx_bit));
        chk("tx crc", 16'hFFFE, tx_crc);
    endtask : t_tx
    task automatic t_rx();
        wr(rph_pkg::ADR_CTRL_LO, 8'h01);
        wr(rph_pkg::ADR_CTRL_UP, 8'h07);
        pkt(8'h01, 8'hFF, 2, 1'b1);
        pkt(8'h01, 8'h00, 2, 1'b1);
        pkt(8'h01, 8'h5A, 2, 1'b0);
        wr(rph_pkg::ADR_CTRL_UP, 8'h05);
        wr(rph_pkg::ADR_DEV_ADR, 8'h5A);
        pkt(8'h01, 8'h5A, 2, 1'b1);
        pkt(8'h01, 8'hFF, 2, 1'b0);
        wr(rph_pkg::ADR_PKT_LEN, 8'h01);
        pkt(8'h02, 8'h5A, 1, 1'b0);
        wr(rph_pkg::ADR_CTRL_UP, 8'h04);
        wr(rph_pkg::ADR_CTRL_LO, 8'h00);
        pkt(8'h77, 8'h00, 1, 1'b1);
        wr(rph_pkg::ADR_CTRL_UP, 8'hE4);
        pkt(8'h01, 8'h00, 0, 1'b0);
    endtask : t_rx
    // frame: length 01, payload 00, then the crc word c; st is the last status byte
    task automatic crc_pkt(input logic [15:0] c, input logic [7:0] st);
        logic [47:0] f;
        f = {32'hD391_0100, c};
        rxq.delete();
        for (int i = 5; i >= 0; i--) radio.send_byte(f[i*8 +: 8]);
        radio.release_line();
        repeat (20) @(posedge mclk_i);
        chk("crc byte count", 16'h0004, 16'(rxq.size()));
        chk("crc status", {7'h00, 1'b1, st}, 16'(rxq[3]));
        chk("crc ok", 16'(st[7]), 16'(crc_ok));
    endtask : crc_pkt
    task automatic t_crc();
        wr(rph_pkg::ADR_CTRL_UP, 8'h04);
        wr(rph_pkg::ADR_CTRL_LO, 8'h05);
        crc_pkt(16'h060E, 8'hB3);
        rd(rph_pkg::ADR_STATUS, 8'h02);
        rd(rph_pkg::ADR_PQ_CNT, 8'h00);
        crc_pkt(16'h060F, 8'h33);
        wr(rph_pkg::ADR_CTRL_LO, 8'h0D);
        crc_pkt(16'h2E3E, 8'hB3);
    endtask : t_crc

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial begin
        {rst_n_i, reg_wr_i, reg_rd_i, tx_start_i, tx_req_i, tx_bit_i} = '0;
        reg_addr_i  = 16'h0000;
        reg_wdata_i = 8'h00;
        rssi        = 8'h5A;
        lqi         = 7'h33;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_debug();
        t_tx();
        t_rx();
        t_crc();
        results();
    end
    // frames take about 3800 cycles; allow over seven times that
    initial begin
        #3000000;
        n_mismatch++;
        results();
    end
endmodule : rph_core_tb
